// [core/dcca_top.sv]
// Dual capture/compare array: timers, channels, register port and interrupt
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns

module dcca_top
  import dcca_pkg::*;
#(
  parameter int NCH = DCCA_NCH
)(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Register port
  input  wire dcca_bus_t         bus,
  output logic [31:0]            rdata,
  // External timer sources
  input  wire logic              gpt_ovf,
  input  wire logic [1:0]        count_pin,
  // Channel pins
  input  wire logic [NCH-1:0]    pin_in,
  output logic [NCH-1:0]         pin_out,
  output logic [NCH-1:0]         pin_oe_n,
  // Interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prescaler tick: low (3+sel) bits of the free counter all ones
  function automatic logic presc_tick(input logic [9:0] c, input logic [2:0] s);
    return &(c | (10'h3FF << (4'(s) + DCCA_PRESC_LOG)));
  endfunction

  // Address falls inside a masked register window
  function automatic logic in_win(input logic [8:0] a, input logic [8:0] base, input logic [8:0] msk);
    return (a & ~msk) == base;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [9:0]          cnt_q,  cnt_d;
  logic [1:0]          cin_q,  cin_d;
  dcca_tctl_t          tctl_q [DCCA_NTMR];
  dcca_tctl_t          tctl_d [DCCA_NTMR];
  logic [15:0]         tmr_q  [DCCA_NTMR];
  logic [15:0]         tmr_d  [DCCA_NTMR];
  logic [15:0]         rld_q  [DCCA_NTMR];
  logic [15:0]         rld_d  [DCCA_NTMR];
  logic [DCCA_NTMR-1:0] tick, ovf;
  logic [15:0]         ccv_q  [NCH];
  logic [15:0]         ccv_d  [NCH];
  dcca_ccfg_t          ccfg_q [NCH];
  dcca_ccfg_t          ccfg_d [NCH];
  logic [NCH-1:0]      pin_q, pin_d, pprev_q, pprev_d, once_q, once_d;
  logic [NCH-1:0]      stat_q, stat_d, ien_q, ien_d;
  logic [NCH-1:0]      capt, cmp, hit, evt, tog;
  logic [31:0]         rd_q, rd_d;

  // ----------------------------------------------------------------
  // Time-base timers
  // ----------------------------------------------------------------
  // Tick select, count, overflow reload, software access
  always_comb
  begin
    cnt_d = cnt_q + 10'h001;
    cin_d = count_pin;
    for (int k = 0; k < DCCA_NTMR; k++)
    begin
      tctl_d[k] = tctl_q[k];
      rld_d[k]  = rld_q[k];
      unique case (tctl_q[k].src)
        SRC_PRESC: tick[k] = presc_tick(cnt_q, tctl_q[k].isel);
        SRC_GPT:   tick[k] = gpt_ovf;
        SRC_PIN:   tick[k] = (k % 2 == 0) && count_pin[k/2] && !cin_q[k/2];
        default:   tick[k] = 1'b0;
      endcase
      tick[k] = tick[k] & tctl_q[k].run;
      ovf[k]  = tick[k] && (tmr_q[k] == TMR_MAX);
      tmr_d[k] = !tick[k] ? tmr_q[k] : (ovf[k] ? rld_q[k] : tmr_q[k] + 16'h0001);
      if (bus.we && in_win(bus.addr, ADDR_TMR_CTL, MASK_TMR) && bus.addr[3:2] == 2'(k))
        tctl_d[k] = dcca_tctl_t'(bus.wdata[5:0]);
      if (bus.we && in_win(bus.addr, ADDR_TMR_VAL, MASK_TMR) && bus.addr[3:2] == 2'(k))
        tmr_d[k] = bus.wdata[15:0];
      if (bus.we && in_win(bus.addr, ADDR_TMR_RLD, MASK_TMR) && bus.addr[3:2] == 2'(k))
        rld_d[k] = bus.wdata[15:0];
    end
  end

  // Timer registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      cin_q <= '0;
      for (int k = 0; k < DCCA_NTMR; k++)
      begin
        tctl_q[k] <= TCTL_RST;
        tmr_q[k]  <= TMR_RST;
        rld_q[k]  <= TMR_RST;
      end
    end
    else
    begin
      cnt_q <= cnt_d;
      cin_q <= cin_d;
      tctl_q <= tctl_d;
      tmr_q  <= tmr_d;
      rld_q  <= rld_d;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Capture, compare, pin actions and interrupt status
  always_comb
  begin
    logic [1:0] k;
    logic [4:0] tgt;
    k        = 2'h0;
    tgt      = 5'h00;
    pprev_d  = pin_in;
    once_d   = once_q;
    pin_d    = pin_q;
    tog      = '0;
    for (int i = 0; i < NCH; i++)
    begin
      k = {i[4], ccfg_q[i].alloc};
      ccfg_d[i] = ccfg_q[i];
      ccv_d[i]  = ccv_q[i];
      capt[i] = (ccfg_q[i].mode == CC_CAPT) &&
                ((ccfg_q[i].edge_sel[0] && pin_in[i] && !pprev_q[i]) ||
                 (ccfg_q[i].edge_sel[1] && !pin_in[i] && pprev_q[i]));
      cmp[i]  = (ccfg_q[i].mode >= CC_CMP0) && tick[k] && (tmr_d[k] == ccv_q[i]);
      // Overflow re-arms, so a match in the overflow cycle opens the new period
      hit[i]  = cmp[i] && (ccfg_q[i].mode inside {CC_CMP2, CC_CMP3}) && (!once_q[i] || ovf[k]);
      once_d[i] = (ovf[k] ? 1'b0 : once_q[i]) | hit[i];
      evt[i]  = capt[i] | hit[i] |
                (cmp[i] && (ccfg_q[i].mode inside {CC_CMP0, CC_CMP1, CC_DBL}));
      if (bus.we && in_win(bus.addr, ADDR_CH_CFG, MASK_CH) && bus.addr[6:2] == 5'(i))
        ccfg_d[i] = dcca_ccfg_t'(bus.wdata[5:0]);
      if (capt[i])
        ccv_d[i] = tmr_q[k];
      else if (bus.we && in_win(bus.addr, ADDR_CH_VAL, MASK_CH) && bus.addr[6:2] == 5'(i))
        ccv_d[i] = bus.wdata[15:0];
      // Double mode pairs channel n and n+8 on the lower pin
      tgt = (ccfg_q[i].mode == CC_DBL) ? {i[4], 1'b0, i[2:0]} : 5'(i);
      if (cmp[i] && (ccfg_q[i].mode inside {CC_CMP1, CC_DBL}))
        tog[tgt] = ~tog[tgt];
    end
    for (int i = 0; i < NCH; i++)
    begin
      k = {i[4], ccfg_q[i].alloc};
      if (ccfg_q[i].mode == CC_CMP3)
        pin_d[i] = hit[i] ? 1'b1 : (ovf[k] ? 1'b0 : pin_q[i]);
      else
        pin_d[i] = pin_q[i] ^ tog[i];
    end
    stat_d = evt;
    stat_d = stat_d | (stat_q & ~((bus.we && bus.addr == ADDR_IRQ_CLR) ? bus.wdata : '0));
    ien_d  = (bus.we && bus.addr == ADDR_IRQ_EN) ? bus.wdata : ien_q;
  end

  // Channel registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ccv_q[i]  <= TMR_RST;
        ccfg_q[i] <= CCFG_RST;
      end
      pin_q   <= '0;
      pprev_q <= '0;
      once_q  <= '0;
      stat_q  <= '0;
      ien_q   <= '0;
    end
    else
    begin
      ccv_q   <= ccv_d;
      ccfg_q  <= ccfg_d;
      pin_q   <= pin_d;
      pprev_q <= pprev_d;
      once_q  <= once_d;
      stat_q  <= stat_d;
      ien_q   <= ien_d;
    end
  end

  // Pin drive: compare modes 1, 3 and lower double partner
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      pin_oe_n[i] = !((ccfg_q[i].mode inside {CC_CMP1, CC_CMP3}) ||
                      (ccfg_q[i].mode == CC_DBL && !i[3]));
  end

  assign pin_out = pin_q;
  assign irq     = |(stat_q & ien_q);

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data decode, answered one cycle after the strobe
  always_comb
  begin
    rd_d = WORD_RST;
    if (bus.re)
    begin
      if (in_win(bus.addr, ADDR_CH_VAL, MASK_CH))
        rd_d = {16'h0000, ccv_q[bus.addr[6:2]]};
      else if (in_win(bus.addr, ADDR_CH_CFG, MASK_CH))
        rd_d = {26'h0000000, ccfg_q[bus.addr[6:2]]};
      else if (in_win(bus.addr, ADDR_TMR_CTL, MASK_TMR))
        rd_d = {26'h0000000, tctl_q[bus.addr[3:2]]};
      else if (in_win(bus.addr, ADDR_TMR_VAL, MASK_TMR))
        rd_d = {16'h0000, tmr_q[bus.addr[3:2]]};
      else if (in_win(bus.addr, ADDR_TMR_RLD, MASK_TMR))
        rd_d = {16'h0000, rld_q[bus.addr[3:2]]};
      else if (bus.addr == ADDR_IRQ_STAT)
        rd_d = stat_q;
      else if (bus.addr == ADDR_IRQ_EN)
        rd_d = ien_q;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_q <= WORD_RST;
    else
      rd_q <= rd_d;
  end

  assign rdata = rd_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Timer seen by capture channel 20 of unit b
  logic [15:0] cap_tv;
  assign cap_tv = tmr_q[{1'b1, ccfg_q[20].alloc}];

  property p_capt_load;
    capt[20] |=> ccv_q[20] == $past(cap_tv);
  endproperty
  a_capt_load: assert property (p_capt_load) else $error("capture value wrong");

  property p_capt_irq;
    capt[20] |=> stat_q[20];
  endproperty
  a_capt_irq: assert property (p_capt_irq) else $error("capture flag missing");

  property p_presc8;
    tctl_q[1].run && tctl_q[1].src == SRC_PRESC && tctl_q[1].isel == 3'h0 |-> tick[1] == (cnt_q[2:0] == 3'h7);
  endproperty
  a_presc8: assert property (p_presc8) else $error("divide by 8 tick wrong");

  property p_reload;
    ovf[0] && !bus.we |=> tmr_q[0] == $past(rld_q[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missing");

  property p_tog1;
    ccfg_q[4].mode == CC_CMP1 && cmp[4] && !cmp[12] |=> pin_out[4] != $past(pin_out[4]);
  endproperty
  a_tog1: assert property (p_tog1) else $error("mode 1 toggle missing");

  property p_mode3;
    ccfg_q[4].mode == CC_CMP3 && hit[4] |=> pin_out[4] ##0 stat_q[4];
  endproperty
  a_mode3: assert property (p_mode3) else $error("mode 3 set wrong");

  property p_once2;
    hit[4] |=> !hit[4];
  endproperty
  a_once2: assert property (p_once2) else $error("second mode 2 event");

  property p_mode0_pin;
    ccfg_q[4].mode == CC_CMP0 |-> pin_oe_n[4] && !evt[4] == !cmp[4];
  endproperty
  a_mode0_pin: assert property (p_mode0_pin) else $error("mode 0 pin or flag wrong");

  property p_pin_irq;
    ccfg_q[4].mode inside {CC_CMP1, CC_DBL} && cmp[4] |=> stat_q[4];
  endproperty
  a_pin_irq: assert property (p_pin_irq) else $error("pin match flag missing");

  c_capture: cover property (capt[20] ##1 stat_q[20]);
  c_toggle:  cover property (ccfg_q[4].mode == CC_CMP1 && cmp[4]);
  c_mode3:   cover property (hit[4] ##[1:300] ovf[0]);
  c_double:  cover property (ccfg_q[5].mode == CC_DBL && cmp[5]);

endmodule // dcca_top

// [core/dcca_pkg.sv]
// Shared constants and types of the dual capture/compare array
package dcca_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          DCCA_NCH       = 32;
  localparam int          DCCA_NTMR      = 4;
  localparam int          DCCA_TW        = 16;
  localparam int          DCCA_PRESC_W   = 10;
  localparam logic [3:0]  DCCA_PRESC_LOG = 4'h3;      // Code 000b divides by 8

  // ----------------------------------------------------------------
  // Register byte addresses and decode masks
  // ----------------------------------------------------------------
  localparam logic [8:0]  ADDR_CH_VAL    = 9'h000;    // 32 channel value words
  localparam logic [8:0]  ADDR_CH_CFG    = 9'h080;    // 32 channel config words
  localparam logic [8:0]  MASK_CH        = 9'h07C;
  localparam logic [8:0]  ADDR_TMR_CTL   = 9'h100;    // 4 timer control words
  localparam logic [8:0]  ADDR_TMR_VAL   = 9'h110;    // 4 timer count words
  localparam logic [8:0]  ADDR_TMR_RLD   = 9'h120;    // 4 timer reload words
  localparam logic [8:0]  MASK_TMR       = 9'h00C;
  localparam logic [8:0]  ADDR_IRQ_STAT  = 9'h130;
  localparam logic [8:0]  ADDR_IRQ_CLR   = 9'h134;
  localparam logic [8:0]  ADDR_IRQ_EN    = 9'h138;

  // ----------------------------------------------------------------
  // Reset values and timer maximum
  // ----------------------------------------------------------------
  localparam logic [15:0] TMR_RST        = 16'h0000;
  localparam logic [15:0] TMR_MAX        = 16'hFFFF;
  localparam logic [31:0] WORD_RST       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {CC_OFF, CC_CAPT, CC_CMP0, CC_CMP1, CC_CMP2, CC_CMP3, CC_DBL} dcca_mode_t;
  typedef enum logic [1:0] {SRC_PRESC, SRC_GPT, SRC_PIN} dcca_src_t;

  typedef struct packed {
    logic       run;
    dcca_src_t  src;
    logic [2:0] isel;
  } dcca_tctl_t;

  typedef struct packed {
    logic [1:0] edge_sel;                             // Bit0 rising, bit1 falling
    logic       alloc;                                // 0 first timer, 1 second timer
    dcca_mode_t mode;
  } dcca_ccfg_t;

  typedef struct packed {
    logic [8:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } dcca_bus_t;

  localparam dcca_tctl_t TCTL_RST = '{run: 1'b0, src: SRC_PRESC, isel: 3'h0};
  localparam dcca_ccfg_t CCFG_RST = '{edge_sel: 2'h0, alloc: 1'b0, mode: CC_OFF};

endpackage

// [tb/dcca_pins_model.sv]
// Far-side model of the channel pins and external timer sources
`timescale 1ns/1ns
module dcca_pins_model
  import dcca_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Device pins
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe_n,
  output logic [31:0]      pin_in,
  // Timer sources
  output logic             gpt_ovf,
  output logic [1:0]       count_pin
);
  logic [31:0] ext_q;

  // Idle levels at time zero
  initial
  begin
    ext_q     = 32'h0000_0000;
    gpt_ovf   = 1'b0;
    count_pin = 2'h0;
  end

  // Device drive wins where its enable is low
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_q);

  // Outside level change on one pin
  task automatic set_pin(input int ch, input logic v);
    @(posedge sys_clk);
    ext_q[ch] <= v;
  endtask

  // One overflow pulse of the general timer
  task automatic gpt_pulse();
    @(posedge sys_clk);
    gpt_ovf <= 1'b1;
    @(posedge sys_clk);
    gpt_ovf <= 1'b0;
  endtask

  // One rising event on a count pin
  task automatic count_pulse(input int u);
    @(posedge sys_clk);
    count_pin[u] <= 1'b1;
    @(posedge sys_clk);
    count_pin[u] <= 1'b0;
  endtask
endmodule // dcca_pins_model

// [tb/tb_top.sv]
// Self-checking testbench of the dual capture/compare array
`timescale 1ns/1ns
module tb_top
  import dcca_pkg::*;
;
  // Design connections
  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  dcca_bus_t   bus      = '0;
  logic [31:0] rdata;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe_n;
  logic        gpt_ovf;
  logic [1:0]  count_pin;
  logic        irq;
  int          errors   = 0;
  int          compares = 0;

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  dcca_top uut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .gpt_ovf(gpt_ovf),
    .count_pin(count_pin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  dcca_pins_model pins (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_in(pin_in), .gpt_ovf(gpt_ovf), .count_pin(count_pin));

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0] ad(input logic [8:0] b, input int n);
    return b + 9'(4 * n);
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.we    <= 1'b1;
    @(posedge sys_clk);
    bus.we    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.re   <= 1'b1;
    @(posedge sys_clk);
    bus.re   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string what, input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(what, d, exp);
  endtask

  // Status, line and pin of channel 4 after a compare step
  task automatic cmp_chk(input logic s, input logic p, input logic drv);
    rchk("cmp_stat", ADDR_IRQ_STAT, 32'(s) << 4);
    chk("cmp_irq", 32'(irq), 32'(s));
    if (drv)
      chk("cmp_pin", 32'(pin_out[4]), 32'(p));
    wr(ADDR_IRQ_CLR, 32'hFFFF_FFFF);
  endtask

  task automatic end_sim();
    $display("Counts: compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("oe_n_rst", pin_oe_n, 32'hFFFF_FFFF);
    chk("irq_rst", 32'(irq), 32'h0000_0000);
    rchk("cfg31_rst", ad(ADDR_CH_CFG, 31), 32'h0000_0000);
    wr(9'h1FC, 32'hFFFF_FFFF);
    rchk("unmapped", 9'h1FC, 32'h0000_0000);
    wr(ADDR_IRQ_STAT, 32'hFFFF_FFFF);
    rchk("stat_ro", ADDR_IRQ_STAT, 32'h0000_0000);
    $display("Test reset done");
  endtask

  task automatic t_presc();
    logic [31:0] a;
    logic [31:0] b;
    for (int s = 0; s < 8; s++)
    begin
      wr(ad(ADDR_TMR_CTL, 1), 32'(32 + s));
      rd_reg(ad(ADDR_TMR_VAL, 1), a);
      repeat ((2 << (3 + s)) - 2) @(posedge sys_clk);
      rd_reg(ad(ADDR_TMR_VAL, 1), b);
      chk("presc_ticks", b - a, 32'h0000_0002);
    end
    wr(ad(ADDR_TMR_CTL, 1), 32'h0000_0000);
    $display("Test prescaler done");
  endtask

  task automatic t_reload();
    wr(ADDR_TMR_CTL, 32'h0000_0028);
    wr(ADDR_TMR_RLD, 32'h0000_1234);
    wr(ADDR_TMR_VAL, 32'h0000_FFFE);
    repeat (3) pins.gpt_pulse();
    rchk("reload", ADDR_TMR_VAL, 32'h0000_1235);
    wr(ADDR_TMR_RLD, 32'h0000_0000);
    wr(ADDR_TMR_VAL, 32'h0000_FFFF);
    pins.gpt_pulse();
    rchk("full_range", ADDR_TMR_VAL, 32'h0000_0000);
    wr(ad(ADDR_TMR_CTL, 2), 32'h0000_0030);
    repeat (3) pins.count_pulse(1);
    rchk("count_pin", ad(ADDR_TMR_VAL, 2), 32'h0000_0003);
    $display("Test timers done");
  endtask

  task automatic t_capture();
    logic hit;
    for (int e = 1; e < 4; e++)
      for (int f = 0; f < 2; f++)
      begin
        hit = ((e >> f) & 1) == 1;
        wr(ad(ADDR_CH_CFG, 20), 32'(9 + 16 * e));
        wr(ad(ADDR_CH_VAL, 20), 32'h0000_0000);
        wr(ADDR_IRQ_CLR, 32'hFFFF_FFFF);
        wr(ad(ADDR_TMR_VAL, 3), 32'(256 * f + 16 + e));
        pins.set_pin(20, f == 0);
        repeat (2) @(posedge sys_clk);
        rchk("capt_val", ad(ADDR_CH_VAL, 20), hit ? 32'(256 * f + 16 + e) : 32'h0);
        rchk("capt_irq", ADDR_IRQ_STAT, hit ? 32'h0010_0000 : 32'h0000_0000);
        chk("capt_oe_n", 32'(pin_oe_n[20]), 32'h0000_0001);
      end
    $display("Test capture done");
  endtask

  task automatic t_compare();
    logic drv;
    wr(ADDR_IRQ_EN, 32'hFFFF_FFFF);
    for (int m = 0; m < 4; m++)
    begin
      drv = (m == 1 || m == 3);
      wr(ad(ADDR_CH_CFG, 4), 32'(m + 2));
      wr(ad(ADDR_CH_VAL, 4), 32'h0000_0040);
      // Overflow first so each mode starts in a fresh period
      wr(ADDR_TMR_VAL, 32'h0000_FFFF);
      pins.gpt_pulse();
      wr(ADDR_IRQ_CLR, 32'hFFFF_FFFF);
      wr(ADDR_TMR_VAL, 32'h0000_003F);
      pins.gpt_pulse();
      chk("cmp_oe_n", 32'(pin_oe_n[4]), 32'(!drv));
      cmp_chk(1'b1, 1'b1, drv);
      wr(ADDR_TMR_VAL, 32'h0000_003F);
      pins.gpt_pulse();
      cmp_chk(m < 2, m == 3, drv);
      wr(ADDR_TMR_VAL, 32'h0000_FFFF);
      pins.gpt_pulse();
      cmp_chk(1'b0, 1'b0, drv);
      wr(ADDR_TMR_VAL, 32'h0000_003F);
      pins.gpt_pulse();
      cmp_chk(1'b1, 1'b1, drv);
    end
    $display("Test compare done");
  endtask

  task automatic t_double();
    wr(ad(ADDR_CH_CFG, 5), 32'h0000_0006);
    wr(ad(ADDR_CH_CFG, 13), 32'h0000_0006);
    wr(ad(ADDR_CH_VAL, 5), 32'h0000_0050);
    wr(ad(ADDR_CH_VAL, 13), 32'h0000_0052);
    wr(ADDR_IRQ_CLR, 32'hFFFF_FFFF);
    wr(ADDR_TMR_VAL, 32'h0000_004F);
    pins.gpt_pulse();
    #1 chk("dbl_pin_a", 32'(pin_out[5]), 32'h0000_0001);
    repeat (2) pins.gpt_pulse();
    @(posedge sys_clk);
    #1 chk("dbl_pin_b", 32'(pin_out[5]), 32'h0000_0000);
    chk("dbl_oe_n", {30'h0, pin_oe_n[13], pin_oe_n[5]}, 32'h0000_0002);
    rchk("dbl_stat", ADDR_IRQ_STAT, 32'h0000_2020);
    wr(ADDR_IRQ_EN, 32'h0000_0000);
    #1 chk("irq_masked", 32'(irq), 32'h0000_0000);
    wr(ADDR_IRQ_EN, 32'h0000_2000);
    #1 chk("irq_enabled", 32'(irq), 32'h0000_0001);
    $display("Test double register done");
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_presc();
    t_reload();
    t_capture();
    t_compare();
    t_double();
    end_sim();
  end

  // Watchdog against a hang
  initial
  begin
    #4000000;
    errors++;
    end_sim();
  end
endmodule // tb_top
